// ===== src/mch_pkg.sv
// Constants shared by the modulus counter and holding register block
package mch_pkg;

   // Printed offsets are register indices; byte address is four times the index
   localparam logic [9:0] IDX_ACCUM1_HOLD   = 10'h0_b4;
   localparam logic [9:0] IDX_ACCUM0_HOLD   = 10'h0_b5;
   localparam logic [9:0] IDX_MODULUS_COUNT = 10'h0_b6;
   localparam logic [9:0] IDX_CAPTURE0_HOLD = 10'h0_b8;
   localparam logic [9:0] IDX_CAPTURE1_HOLD = 10'h0_ba;
   localparam logic [9:0] IDX_CAPTURE2_HOLD = 10'h0_bc;
   localparam logic [9:0] IDX_CAPTURE3_HOLD = 10'h0_be;
   localparam logic [9:0] IDX_CONTROL       = 10'h0_c0;
   localparam logic [9:0] IDX_STATUS        = 10'h0_c1;
   localparam logic [9:0] IDX_MASK          = 10'h0_c2;

   localparam int         APB_ADDR_W   = 12;
   localparam int         NUM_CAPTURES = 4;
   localparam int         NUM_ACCUMS   = 2;

   // Control register fields
   localparam int         CTL_COUNT_ENABLE  = 0;
   localparam int         CTL_MODULUS_MODE  = 1;
   localparam int         CTL_READ_RELOAD   = 2;
   localparam int         CTL_LATCH_NOT_Q   = 3;
   localparam int         CTL_BUFFER_ENABLE = 4;
   localparam int         CTL_ACCUM0_ENABLE = 5;
   localparam int         CTL_ACCUM1_ENABLE = 6;
   localparam int         CTL_FORCE_LOAD    = 7;
   localparam int         CTL_WIDTH         = 7;

   // Status and mask fields
   localparam int         STS_COUNTER_ZERO  = 0;
   localparam int         STS_LATCH_DONE    = 1;
   localparam int         STS_WIDTH         = 2;

   // Reset values
   localparam logic [15:0] RST_COUNT    = 16'hffff;
   localparam logic [15:0] RST_RELOAD   = 16'hffff;
   localparam logic [15:0] RST_HOLD     = 16'h0000;
   localparam logic [6:0]  RST_CONTROL  = 7'h00;
   localparam logic [1:0]  RST_STATUS   = 2'h0;
   localparam logic [1:0]  RST_MASK     = 2'h0;
   localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

   // Default prescale ratio, in module clocks per down-count
   localparam int         PRESCALE_DEF = 1;

endpackage

// ===== src/mch_counter.sv
// Modulus down-counter with reload register and prescaler
`timescale 1ns/1ps
module mch_counter
#(
   parameter int PRESCALE = mch_pkg::PRESCALE_DEF
)
(
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   // Control
   input  wire logic        wr_i,
   input  wire logic [15:0] wr_data_i,
   input  wire logic        force_i,
   input  wire logic        mod_mode_i,
   input  wire logic        enable_i,
   // State
   output logic      [15:0] count_o,
   output logic      [15:0] reload_o,
   output logic             zero_o
);
   import mch_pkg::*;

   localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
   localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

   if (PRESCALE < 1)
   begin : g_chk
      $error("PRESCALE must be at least one");
   end

   typedef struct packed {
      logic [15:0]   count;
      logic [15:0]   reload;
      logic [PW-1:0] pre;
      logic          zero;
   } mch_cnt_t;

   mch_cnt_t s;
   mch_cnt_t next_s;

   always_comb
   begin
      next_s      = s;
      next_s.zero = 1'b0;
      if (wr_i)
      begin
         next_s.reload = wr_data_i;
         if (wr_data_i == 16'h0000)
         begin
            // Zero write parks the counter without raising the zero event
            next_s.count = 16'h0000;
            next_s.pre   = '0;
         end
         else if (!mod_mode_i)
         begin
            next_s.count = wr_data_i;
            next_s.pre   = '0;
         end
         // Modulus mode: only the reload register moves
      end
      else if (force_i)
      begin
         next_s.count = s.reload;
         next_s.pre   = '0;
      end
      else if (enable_i && s.count != 16'h0000)
      begin
         if (s.pre == PRE_LAST)
         begin
            next_s.pre = '0;
            if (s.count == 16'h0001)
            begin
               next_s.zero  = 1'b1;
               // One-shot stops at zero; modulus mode reloads
               next_s.count = mod_mode_i ? s.reload : 16'h0000;
            end
            else
            begin
               next_s.count = s.count - 16'h0001;
            end
         end
         else
         begin
            next_s.pre = PW'(s.pre + PW'(1));
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s.count  <= RST_COUNT;
         s.reload <= RST_RELOAD;
         s.pre    <= '0;
         s.zero   <= 1'b0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign count_o  = s.count;
   assign reload_o = s.reload;
   assign zero_o   = s.zero;

endmodule

// ===== src/mch_hold.sv
// Input capture and pulse accumulator holding registers
`timescale 1ns/1ps
module mch_hold
(
   // Clock and reset
   input  wire logic                                   core_clk_i,
   input  wire logic                                   reset_n_i,
   // Events
   input  wire logic                                   latch_i,
   input  wire logic                                   queue_mode_i,
   input  wire logic [mch_pkg::NUM_CAPTURES-1:0]       cap_evt_i,
   // Live values
   input  wire logic [mch_pkg::NUM_CAPTURES-1:0][15:0] cap_val_i,
   input  wire logic [mch_pkg::NUM_ACCUMS-1:0][7:0]    acc_val_i,
   input  wire logic [mch_pkg::NUM_ACCUMS-1:0]         acc_en_i,
   // Software writes to accumulator holds
   input  wire logic [mch_pkg::NUM_ACCUMS-1:0]         acc_wr_i,
   input  wire logic [7:0]                             wr_data_i,
   // Held values
   output logic      [mch_pkg::NUM_CAPTURES-1:0][15:0] cap_hold_o,
   output logic      [mch_pkg::NUM_ACCUMS-1:0][7:0]    acc_hold_o
);
   import mch_pkg::*;

   typedef struct packed {
      logic [NUM_CAPTURES-1:0][15:0] cap;
      logic [NUM_ACCUMS-1:0][7:0]    acc;
   } mch_hold_t;

   mch_hold_t s;
   mch_hold_t next_s;

   always_comb
   begin
      next_s = s;
      for (int c = 0; c < NUM_CAPTURES; c++)
      begin
         // Capture register still holds the previous value at this edge
         if (latch_i || (queue_mode_i && cap_evt_i[c]))
         begin
            next_s.cap[c] = cap_val_i[c];
         end
      end
      for (int a = 0; a < NUM_ACCUMS; a++)
      begin
         if (latch_i && acc_en_i[a])
         begin
            next_s.acc[a] = acc_val_i[a];
         end
         else if (acc_wr_i[a])
         begin
            next_s.acc[a] = wr_data_i;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign cap_hold_o = s.cap;
   assign acc_hold_o = s.acc;

endmodule

// ===== src/mch_top.sv
// Modulus count register and holding registers behind an APB slave
//
// How it works
// - An enabled 8-bit accumulator is copied into its hold register on every latch event.
// - With read_reload_select clear, reading modulus_count gives the live count.
// - With read_reload_select set, reading modulus_count gives the reload value.
// - Writing zero to modulus_count latches the capture holds and the enabled accumulator holds when latch mode and buffering are on.
// - A zero write leaves the counter at zero and raises no counter_zero_flag.
// - In modulus mode a nonzero count write only changes the reload, taken at the next underflow.
// - Writing force_load_now copies the reload into the counter at once.
// - Outside modulus mode a count write clears the prescaler, loads and counts once to zero.
// - Four capture holds take the values of the four lowest capture registers.
// - Capture holds read at any time and ignore writes.
// - A latch event moves captures and enabled accumulators to holds, then clears those accumulators.
// - In queue mode a new capture first moves the old capture value into its hold.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module mch_top
#(
   parameter int PRESCALE = mch_pkg::PRESCALE_DEF
)
(
   // Clock and reset
   input  wire logic                                   core_clk_i,
   input  wire logic                                   reset_n_i,
   // APB slave
   input  wire logic                                   psel_i,
   input  wire logic                                   penable_i,
   input  wire logic                                   pwrite_i,
   input  wire logic [mch_pkg::APB_ADDR_W-1:0]         paddr_i,
   input  wire logic [31:0]                            pwdata_i,
   input  wire logic [3:0]                             pstrb_i,
   output logic      [31:0]                            prdata_o,
   output logic                                        pready_o,
   output logic                                        pslverr_o,
   // Timer capture side
   input  wire logic [mch_pkg::NUM_CAPTURES-1:0]       cap_evt_i,
   input  wire logic [mch_pkg::NUM_CAPTURES-1:0][15:0] cap_val_i,
   input  wire logic [mch_pkg::NUM_ACCUMS-1:0][7:0]    acc_val_i,
   output logic      [mch_pkg::NUM_ACCUMS-1:0]         acc_clear_o,
   // Interrupt
   output logic                                        irq_o
);
   import mch_pkg::*;

   typedef struct packed {
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
      logic [CTL_WIDTH-1:0] control;
      logic [STS_WIDTH-1:0] status;
      logic [STS_WIDTH-1:0] mask;
      logic [NUM_ACCUMS-1:0] acc_clear;
      logic                 irq;
   } mch_top_t;

   mch_top_t s;
   mch_top_t next_s;

   logic [15:0]                   count;
   logic [15:0]                   reload;
   logic                          ctr_zero;
   logic [NUM_CAPTURES-1:0][15:0] cap_hold;
   logic [NUM_ACCUMS-1:0][7:0]    acc_hold;

   logic [9:0]                    idx;
   logic                          access;
   logic                          wr;
   logic                          mapped;
   logic                          wr_count;
   logic [15:0]                   count_wdata;
   logic                          force_load;
   logic                          latch_mode;
   logic                          latch_now;
   logic [NUM_ACCUMS-1:0]         acc_wr;
   logic [NUM_ACCUMS-1:0]         acc_en;
   logic [31:0]                   rd_value;

   assign idx    = paddr_i[11:2];
   // Transfer completes in the access cycle; pready rises one edge after setup
   assign access = psel_i && penable_i && s.pready;
   assign wr     = access && pwrite_i;

   always_comb
   begin
      mapped = 1'b1;
      case (idx)
         IDX_ACCUM1_HOLD:   mapped = 1'b1;
         IDX_ACCUM0_HOLD:   mapped = 1'b1;
         IDX_MODULUS_COUNT: mapped = 1'b1;
         IDX_CAPTURE0_HOLD: mapped = 1'b1;
         IDX_CAPTURE1_HOLD: mapped = 1'b1;
         IDX_CAPTURE2_HOLD: mapped = 1'b1;
         IDX_CAPTURE3_HOLD: mapped = 1'b1;
         IDX_CONTROL:       mapped = 1'b1;
         IDX_STATUS:        mapped = 1'b1;
         IDX_MASK:          mapped = 1'b1;
         default:           mapped = 1'b0;
      endcase
   end

   assign latch_mode = s.control[CTL_LATCH_NOT_Q] && s.control[CTL_BUFFER_ENABLE];
   assign acc_en     = {s.control[CTL_ACCUM1_ENABLE], s.control[CTL_ACCUM0_ENABLE]};

   // Unwritten byte lanes keep the reload value; split byte writes differ from word writes
   assign count_wdata = {pstrb_i[1] ? pwdata_i[15:8] : reload[15:8],
                         pstrb_i[0] ? pwdata_i[7:0]  : reload[7:0]};
   assign wr_count    = wr && (idx == IDX_MODULUS_COUNT);
   assign force_load  = wr && (idx == IDX_CONTROL) && pwdata_i[CTL_FORCE_LOAD];

   // Latch on a zero write or when the count reaches zero
   assign latch_now = latch_mode &&
                      ((wr_count && count_wdata == 16'h0000) || ctr_zero);

   assign acc_wr[1] = wr && (idx == IDX_ACCUM1_HOLD) && pstrb_i[0];
   assign acc_wr[0] = wr && (idx == IDX_ACCUM0_HOLD) && pstrb_i[0];

   always_comb
   begin
      rd_value = READ_ZERO;
      case (idx)
         IDX_ACCUM1_HOLD:   rd_value = {24'h00_0000, acc_hold[1]};
         IDX_ACCUM0_HOLD:   rd_value = {24'h00_0000, acc_hold[0]};
         IDX_MODULUS_COUNT:
         begin
            rd_value = {16'h0000, s.control[CTL_READ_RELOAD] ? reload : count};
         end
         IDX_CAPTURE0_HOLD: rd_value = {16'h0000, cap_hold[0]};
         IDX_CAPTURE1_HOLD: rd_value = {16'h0000, cap_hold[1]};
         IDX_CAPTURE2_HOLD: rd_value = {16'h0000, cap_hold[2]};
         IDX_CAPTURE3_HOLD: rd_value = {16'h0000, cap_hold[3]};
         IDX_CONTROL:       rd_value = {25'h000_0000, s.control};
         IDX_STATUS:        rd_value = {30'h0000_0000, s.status};
         IDX_MASK:          rd_value = {30'h0000_0000, s.mask};
         default:           rd_value = READ_ZERO;
      endcase
   end

   always_comb
   begin
      next_s           = s;
      next_s.pready    = psel_i && !penable_i && !s.pready;
      next_s.acc_clear = '0;
      if (psel_i && !penable_i)
      begin
         next_s.prdata  = pwrite_i ? READ_ZERO : rd_value;
         next_s.pslverr = !mapped;
      end
      else if (access)
      begin
         next_s.prdata  = READ_ZERO;
         next_s.pslverr = 1'b0;
      end

      if (wr && idx == IDX_CONTROL)
      begin
         // Force-load is a strobe and never stored
         next_s.control = pwdata_i[CTL_WIDTH-1:0];
      end
      if (wr && idx == IDX_MASK)
      begin
         next_s.mask = pwdata_i[STS_WIDTH-1:0];
      end
      // Capture hold writes fall through with no effect

      // Write-one-to-clear first, then a new event in the same cycle wins
      if (wr && idx == IDX_STATUS)
      begin
         next_s.status = s.status & ~pwdata_i[STS_WIDTH-1:0];
      end
      if (ctr_zero)
      begin
         next_s.status[STS_COUNTER_ZERO] = 1'b1;
      end
      if (latch_now)
      begin
         next_s.status[STS_LATCH_DONE] = 1'b1;
         // Accumulators clear after their values move to the holds
         next_s.acc_clear = acc_en;
      end

      next_s.irq = |(next_s.status & next_s.mask);
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s.prdata    <= READ_ZERO;
         s.pready    <= 1'b0;
         s.pslverr   <= 1'b0;
         s.control   <= RST_CONTROL;
         s.status    <= RST_STATUS;
         s.mask      <= RST_MASK;
         s.acc_clear <= '0;
         s.irq       <= 1'b0;
      end
      else
      begin
         s <= next_s;
      end
   end

   mch_counter #(
      .PRESCALE (PRESCALE)
   ) u_counter (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .wr_i       (wr_count),
      .wr_data_i  (count_wdata),
      .force_i    (force_load),
      .mod_mode_i (s.control[CTL_MODULUS_MODE]),
      .enable_i   (s.control[CTL_COUNT_ENABLE]),
      .count_o    (count),
      .reload_o   (reload),
      .zero_o     (ctr_zero)
   );

   mch_hold u_hold (
      .core_clk_i   (core_clk_i),
      .reset_n_i    (reset_n_i),
      .latch_i      (latch_now),
      .queue_mode_i (s.control[CTL_BUFFER_ENABLE] && !s.control[CTL_LATCH_NOT_Q]),
      .cap_evt_i    (cap_evt_i),
      .cap_val_i    (cap_val_i),
      .acc_val_i    (acc_val_i),
      .acc_en_i     (acc_en),
      .acc_wr_i     (acc_wr),
      .wr_data_i    (pwdata_i[7:0]),
      .cap_hold_o   (cap_hold),
      .acc_hold_o   (acc_hold)
   );

   assign prdata_o    = s.prdata;
   assign pready_o    = s.pready;
   assign pslverr_o   = s.pslverr;
   assign acc_clear_o = s.acc_clear;
   assign irq_o       = s.irq;

endmodule

// ===== bench/mch_top_sva.sv
// Bus and latch checks on the ports of the modulus counter block
`timescale 1ns/1ps
module mch_top_sva
(
   // Clock and reset
   input  wire logic                             core_clk_i,
   input  wire logic                             reset_n_i,
   // APB slave
   input  wire logic                             psel_i,
   input  wire logic                             penable_i,
   input  wire logic                             pwrite_i,
   input  wire logic [mch_pkg::APB_ADDR_W-1:0]   paddr_i,
   input  wire logic [31:0]                      pwdata_i,
   input  wire logic [3:0]                       pstrb_i,
   input  wire logic [31:0]                      prdata_o,
   input  wire logic                             pready_o,
   input  wire logic                             pslverr_o,
   // Timer side
   input  wire logic [mch_pkg::NUM_ACCUMS-1:0]   acc_clear_o
);
   import mch_pkg::*;
   // Control is shadowed from bus writes, since the checker cannot see inside
   logic [7:0] ctl_q;
   logic       mapped;
   logic       zero_wr;
   always_ff @(posedge core_clk_i or negedge reset_n_i)
      if (!reset_n_i)
         ctl_q <= 8'h00;
      else if (pready_o && pwrite_i && paddr_i[11:2] == IDX_CONTROL && pstrb_i[0])
         ctl_q <= pwdata_i[7:0];
   assign mapped = paddr_i[11:2] inside {IDX_ACCUM1_HOLD, IDX_ACCUM0_HOLD, IDX_MODULUS_COUNT,
      IDX_CAPTURE0_HOLD, IDX_CAPTURE1_HOLD, IDX_CAPTURE2_HOLD, IDX_CAPTURE3_HOLD,
      IDX_CONTROL, IDX_STATUS, IDX_MASK};
   assign zero_wr = pready_o && pwrite_i && paddr_i[11:2] == IDX_MODULUS_COUNT
      && pwdata_i[15:0] == 16'h0000 && pstrb_i == 4'hf
      && ctl_q[CTL_LATCH_NOT_Q] && ctl_q[CTL_BUFFER_ENABLE];
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_access;
      psel_i && penable_i;
   endsequence
   ready_in_access_a: assert property (pready_o |-> s_access)
      else $error("ready outside an access phase");
   ready_first_access_a: assert property (s_setup ##1 s_access |-> pready_o)
      else $error("ready missing in first access cycle");
   ready_one_cycle_a: assert property (pready_o |=> !pready_o)
      else $error("ready held longer than one cycle");
   error_with_ready_a: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   read_idle_zero_a: assert property (!(pready_o && !pwrite_i) |-> prdata_o == 32'h0000_0000)
      else $error("read data outside a read answer");
   unmapped_error_a: assert property (pready_o && !mapped |-> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped access not refused");
   mapped_no_error_a: assert property (pready_o && mapped |-> !pslverr_o)
      else $error("mapped access refused");
   zero_latch_a: assert property (zero_wr |-> ##[1:2] acc_clear_o == {ctl_q[6], ctl_q[5]})
      else $error("zero write did not clear enabled accumulators");
endmodule

bind mch_top mch_top_sva i_sva (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .acc_clear_o(acc_clear_o));

// ===== bench/tb_top.sv
// Register-level testbench for the modulus counter block
`timescale 1ns/1ps
module tb_top;
   import mch_pkg::*;
   logic              core_clk = 1'b0;
   logic              reset_n;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [11:0]       paddr;
   logic [31:0]       pwdata;
   logic [3:0]        pstrb;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [3:0]        cap_evt;
   logic [3:0][15:0]  cap_val;
   logic [1:0][7:0]   acc_val;
   logic [1:0]        acc_clear;
   logic [1:0]        acc_seen = 2'b00;
   logic              irq;
   logic [31:0]       r;
   logic              e;
   int                num_errors = 0;
   int                num_checks = 0;

   always #12.5 core_clk = ~core_clk;

   mch_top #(.PRESCALE(1)) i_dut (.core_clk_i(core_clk), .reset_n_i(reset_n), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .cap_evt_i(cap_evt), .cap_val_i(cap_val), .acc_val_i(acc_val),
      .acc_clear_o(acc_clear), .irq_o(irq));

   // Keeps the last clear pulse, since it stands for one cycle only
   always @(posedge core_clk)
      if (acc_clear !== 2'b00)
         acc_seen <= acc_clear;

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string msg);
      chk32({31'h0, got}, {31'h0, exp}, msg);
   endtask

   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      // Waits as long as the slave needs; only the watchdog ends a hang
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1);
      // The slave inserts no wait state, so ready comes in the first access cycle
      chk32(32'(n), 32'h0000_0001, "ready latency");
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
      chk1(e, 1'b0, "write error");
   endtask

   task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk32(r, exp, "read data");
   endtask

   initial
   begin
      #(25 * 20000);
      num_errors++;
      summarize();
   end

   initial
   begin
      reset_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, cap_evt, cap_val, acc_val} = '0;
      // Every count access is one whole word with all lanes strobed
      pstrb = 4'hf;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(IDX_MODULUS_COUNT, {16'h0000, RST_COUNT});
      rd(IDX_CAPTURE0_HOLD, 32'h0000_0000);
      rd(IDX_CONTROL, 32'h0000_0000);
      wr(IDX_MODULUS_COUNT, 32'h0000_1234);
      rd(IDX_MODULUS_COUNT, 32'h0000_1234);
      wr(IDX_MODULUS_COUNT, 32'h0000_0005);
      wr(IDX_CONTROL, 32'h0000_0001);
      repeat (20) @(posedge core_clk);
      rd(IDX_MODULUS_COUNT, 32'h0000_0000);
      rd(IDX_STATUS, 32'h0000_0001);
      wr(IDX_STATUS, 32'h0000_0001);
      rd(IDX_STATUS, 32'h0000_0000);
      // Modulus mode with the counter stopped, so only the reload moves
      wr(IDX_CONTROL, 32'h0000_0002);
      wr(IDX_MODULUS_COUNT, 32'h0000_0040);
      rd(IDX_MODULUS_COUNT, 32'h0000_0000);
      wr(IDX_CONTROL, 32'h0000_0006);
      rd(IDX_MODULUS_COUNT, 32'h0000_0040);
      wr(IDX_CONTROL, 32'h0000_0082);
      rd(IDX_MODULUS_COUNT, 32'h0000_0040);
      wr(IDX_CONTROL, 32'h0000_0003);
      repeat (80) @(posedge core_clk);
      rd(IDX_STATUS, 32'h0000_0001);
      chk1(irq, 1'b0, "irq while masked");
      wr(IDX_MASK, 32'h0000_0001);
      repeat (3) @(posedge core_clk);
      chk1(irq, 1'b1, "irq not raised");
      wr(IDX_CONTROL, 32'h0000_0000);
      wr(IDX_STATUS, 32'h0000_0001);
      repeat (3) @(posedge core_clk);
      chk1(irq, 1'b0, "irq not cleared");
      // Latch by zero write, accumulator 1 left disabled
      cap_val <= {16'h4444, 16'h3333, 16'h2222, 16'h1111};
      acc_val <= {8'ha5, 8'h5a};
      wr(IDX_CONTROL, 32'h0000_0038);
      wr(IDX_MODULUS_COUNT, 32'h0000_0000);
      repeat (3) @(posedge core_clk);
      rd(IDX_MODULUS_COUNT, 32'h0000_0000);
      rd(IDX_STATUS, 32'h0000_0002);
      for (int c = 0; c < 4; c++)
         rd(IDX_CAPTURE0_HOLD + 10'(2 * c), {16'h0, cap_val[c]});
      rd(IDX_ACCUM0_HOLD, 32'h0000_005a);
      rd(IDX_ACCUM1_HOLD, 32'h0000_0000);
      chk32({30'h0, acc_seen}, 32'h0000_0001, "accumulator clear");
      wr(IDX_CAPTURE0_HOLD, 32'h0000_ffff);
      rd(IDX_CAPTURE0_HOLD, 32'h0000_1111);
      wr(IDX_ACCUM1_HOLD, 32'h0000_003c);
      rd(IDX_ACCUM1_HOLD, 32'h0000_003c);
      apb(1'b0, 10'h0b7, 32'h0);
      chk1(e, 1'b1, "unmapped not refused");
      chk32(r, 32'h0000_0000, "unmapped data");
      // Queue mode: the capture value driven with the event moves into the hold
      wr(IDX_CONTROL, 32'h0000_0010);
      @(posedge core_clk);
      cap_val[2] <= 16'h7777;
      // Channels behind the holds act as input captures only
      cap_evt <= 4'b0100;
      @(posedge core_clk);
      cap_evt <= 4'b0000;
      rd(IDX_CAPTURE2_HOLD, 32'h0000_7777);
      rd(IDX_CAPTURE1_HOLD, 32'h0000_2222);
      // Second latch with only accumulator 1 enabled
      acc_val <= {8'h96, 8'h69};
      wr(IDX_CONTROL, 32'h0000_0058);
      wr(IDX_MODULUS_COUNT, 32'h0000_0000);
      rd(IDX_ACCUM1_HOLD, 32'h0000_0096);
      rd(IDX_ACCUM0_HOLD, 32'h0000_005a);
      chk32({30'h0, acc_seen}, 32'h0000_0002, "accumulator clear");
      summarize();
   end
endmodule
